// [hdl/aov_defs.svh]
`ifndef AOV_DEFS_SVH
`define AOV_DEFS_SVH
`define AOV_A_SYS       8'h00
`define AOV_A_PASS      8'h04
`define AOV_A_MBADDR    8'h08
`define AOV_A_MBBAUD    8'h0C
`define AOV_A_MBPAR     8'h10
`define AOV_A_CMD       8'h14
`define AOV_A_STATUS    8'h18
`define AOV_A_UNLOCK    8'h1C
`define AOV_A_SENS_EN   8'h20
`define AOV_A_CH_BASE   8'h40
`define AOV_A_CH_END    8'hC0
`define AOV_W_CTRL      2'h0
`define AOV_W_THR_ON    2'h1
`define AOV_W_THR_OFF   2'h2
`define AOV_W_DELAY     2'h3
`define AOV_SYS_BL_LO   0
`define AOV_SYS_BEEP    2
`define AOV_SYS_HALF    3
`define AOV_CMD_RSTLAT  0
`define AOV_CMD_UNHUSH  1
`define AOV_CMD_HUSH    2
`define AOV_DLY_OFF_LO  8
`define AOV_RST_PASS    16'h4321
`define AOV_RST_MBADDR  8'h03
`define AOV_RST_MBBAUD  32'h00004B00
`define AOV_RST_MBPAR   2'h0
`define AOV_RST_VOTE    3'h1
`define AOV_RST_BL      2'h2
`define AOV_RST_BEEP    1'b1
`define AOV_RST_HALF    1'b0
`define AOV_CLK_HZ      50000000
`define AOV_HOLD_S      180
`define AOV_BL_S        10
`define AOV_SEC_PER_MIN 60
`define AOV_BEEP_MS     50
`define AOV_STROBE_MS   500
`endif

// [hdl/aov_pkg.sv]
package aov_pkg;
  typedef struct packed {
    logic       en;
    logic [3:0] src_mask;
    logic       avg;
    logic       latch;
    logic       energ;
    logic       bstyle;
    logic [2:0] vote;
  } aov_chan_ctrl_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] baud;
    logic [1:0]  parity;
  } aov_mb_cfg_t;
  typedef enum logic [1:0] {
    FP_MON  = 2'b00,
    FP_HOLD = 2'b01,
    FP_MENU = 2'b10
  } aov_front_t;
  typedef enum logic [1:0] {
    BL_ON   = 2'b00,
    BL_OFF  = 2'b01,
    BL_AUTO = 2'b10
  } aov_bl_t;
endpackage : aov_pkg

// [hdl/aov_top.sv]
`timescale 1ns/100ps
`include "aov_defs.svh"
// Summary of operation
// - Voting actuates when votes reach minimum count
// - Each channel takes any nonempty enabled-input subset
// - Normal order: vote at or above on
// - Normal order: unvote at or below off
// - Inverted order flips both comparisons
// - Averaging mode ignores vote count
// - Average normal: on at/above, off at/below
// - Average inverted: on at/below, off at/above
// - Four sensors, four relays, three buzzers, strobe
// - Relay indicator follows coil drive level
// - Up/down key enters three-minute hold
// - Exit key leaves hold to scrolling
// - Enter opens menu only from monitoring
// - Latched reset clears only non-alarming channels
// - Unhush rearms outputs through on-delay
// - Strobe continuous or half duty, default continuous
// - New password up to four decimal digits
// - Modbus address, baud, parity with defaults
// - Transmit and receive indicators per port
// - Optional key beep, default enabled
// - Backlight on, off or automatic
// - Automatic backlight lit ten seconds after key
// - Separate on/off delays up to 63 minutes
// - Horn follows any buzzer
// - Latching relay holds until front-panel reset
module aov_top
  import aov_pkg::*;
#(
  parameter int NSENS           = 4,
  parameter int NCH             = 8,
  parameter int CYC_PER_SEC     = `AOV_CLK_HZ,
  parameter int BEEP_CYC        = `AOV_CLK_HZ / 1000 * `AOV_BEEP_MS,
  parameter int STROBE_HALF_CYC = `AOV_CLK_HZ / 1000 * `AOV_STROBE_MS
)(
  input  wire logic                   I_CORE_CLK,
  input  wire logic                   I_ARST_N,
  input  wire logic [7:0]             I_ADDR,
  input  wire logic [31:0]            I_WDATA,
  input  wire logic                   I_WR,
  input  wire logic                   I_RD,
  output logic      [31:0]            O_RDATA,
  input  wire logic [NSENS-1:0][15:0] I_READING,
  input  wire logic                   I_KEY_UP,
  input  wire logic                   I_KEY_DOWN,
  input  wire logic                   I_KEY_ENTER,
  input  wire logic                   I_KEY_EXIT,
  input  wire logic                   I_SENS_TX_ACT,
  input  wire logic                   I_SENS_RX_ACT,
  input  wire logic                   I_MST_TX_ACT,
  input  wire logic                   I_MST_RX_ACT,
  output logic      [3:0]             O_RELAY_COIL,
  output logic      [3:0]             O_RELAY_LED,
  output logic      [2:0]             O_BUZZER,
  output logic                        O_HORN,
  output logic                        O_STROBE,
  output logic                        O_SENS_TX_LED,
  output logic                        O_SENS_RX_LED,
  output logic                        O_MST_TX_LED,
  output logic                        O_MST_RX_LED,
  output logic                        O_AUTO_SCROLL,
  output logic                        O_HOLD,
  output logic                        O_MENU,
  output logic      [2:0]             O_HOLD_ROW,
  output logic                        O_BEEP,
  output logic                        O_BACKLIGHT,
  output aov_mb_cfg_t                 O_MB_CFG
);
  localparam int SECW = $clog2(CYC_PER_SEC);
  localparam int BPW  = $clog2(BEEP_CYC + 1);
  localparam int STW  = $clog2(STROBE_HALF_CYC);

  function automatic logic [2:0] pop4(input logic [3:0] v);
    pop4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
  endfunction : pop4

  function automatic logic bcd_ok(input logic [15:0] v);
    bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) &&
             (v[11:8] <= 4'h9) && (v[15:12] <= 4'h9);
  endfunction : bcd_ok

  aov_chan_ctrl_t ctrl [NCH];
  logic [15:0]    thr_on [NCH];
  logic [15:0]    thr_off [NCH];
  logic [5:0]     dly_on [NCH];
  logic [5:0]     dly_off [NCH];
  logic [NCH-1:0] act;
  logic [NCH-1:0] hushed;
  logic [1:0]     bl_mode;
  logic           beep_en;
  logic           strobe_half;
  logic [15:0]    password;
  logic [3:0]     sens_en;
  aov_mb_cfg_t    mb_cfg;
  aov_front_t     front;
  logic           unlocked;
  logic [2:0]     row;
  logic [7:0]     hold_s;
  logic [3:0]     bl_s;
  logic           bl_on;
  logic [BPW-1:0] beep_cnt;
  logic [SECW-1:0] sec_cnt;
  logic           sec_tick;
  logic [STW-1:0] st_cnt;
  logic           st_phase;

  wire ch_hit = (I_ADDR >= `AOV_A_CH_BASE) && (I_ADDR < `AOV_A_CH_END);
  wire [7:0] ch_off = I_ADDR - `AOV_A_CH_BASE;
  wire [2:0] ch_sel = ch_off[6:4];
  wire [1:0] ch_word = ch_off[3:2];
  wire wr_cmd = I_WR && (I_ADDR == `AOV_A_CMD);
  wire cmd_rstlat = wr_cmd && I_WDATA[`AOV_CMD_RSTLAT];
  wire cmd_unhush = wr_cmd && I_WDATA[`AOV_CMD_UNHUSH];
  wire cmd_hush = wr_cmd && I_WDATA[`AOV_CMD_HUSH];
  wire key_any = I_KEY_UP | I_KEY_DOWN | I_KEY_ENTER | I_KEY_EXIT;
  wire [11:0] hold_last = 12'(`AOV_HOLD_S - 1);

  // Global settings
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      bl_mode     <= `AOV_RST_BL;
      beep_en     <= `AOV_RST_BEEP;
      strobe_half <= `AOV_RST_HALF;
      password    <= `AOV_RST_PASS;
      sens_en     <= 4'h0;
      mb_cfg      <= '{`AOV_RST_MBADDR, `AOV_RST_MBBAUD, `AOV_RST_MBPAR};
    end
    else if (I_WR)
    begin
      unique case (I_ADDR)
        `AOV_A_SYS:
        begin
          bl_mode     <= I_WDATA[`AOV_SYS_BL_LO +: 2];
          beep_en     <= I_WDATA[`AOV_SYS_BEEP];
          strobe_half <= I_WDATA[`AOV_SYS_HALF];
        end
        `AOV_A_PASS:
        begin
          if (bcd_ok(I_WDATA[15:0]))
            password <= I_WDATA[15:0];
        end
        `AOV_A_MBADDR: mb_cfg.addr <= I_WDATA[7:0];
        `AOV_A_MBBAUD: mb_cfg.baud <= I_WDATA;
        `AOV_A_MBPAR: mb_cfg.parity <= I_WDATA[1:0];
        `AOV_A_SENS_EN: sens_en <= I_WDATA[3:0];
        default: ;
      endcase
    end
  end

  // Per-channel configuration
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        ctrl[c]    <= '{1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, `AOV_RST_VOTE};
        thr_on[c]  <= 16'h0000;
        thr_off[c] <= 16'h0000;
        dly_on[c]  <= 6'h00;
        dly_off[c] <= 6'h00;
      end
    end
    else if (I_WR && ch_hit)
    begin
      unique case (ch_word)
        `AOV_W_CTRL: ctrl[ch_sel] <= I_WDATA[11:0];
        `AOV_W_THR_ON: thr_on[ch_sel] <= I_WDATA[15:0];
        `AOV_W_THR_OFF: thr_off[ch_sel] <= I_WDATA[15:0];
        `AOV_W_DELAY:
        begin
          dly_on[ch_sel]  <= I_WDATA[5:0];
          dly_off[ch_sel] <= I_WDATA[`AOV_DLY_OFF_LO +: 6];
        end
      endcase
    end
  end

  // Seconds tick
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      sec_cnt  <= '0;
      sec_tick <= 1'b0;
    end
    else
    begin
      sec_tick <= (sec_cnt == SECW'(CYC_PER_SEC - 1));
      if (sec_cnt == SECW'(CYC_PER_SEC - 1))
        sec_cnt <= '0;
      else
        sec_cnt <= sec_cnt + 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      st_cnt   <= '0;
      st_phase <= 1'b1;
    end
    else if (st_cnt == STW'(STROBE_HALF_CYC - 1))
    begin
      st_cnt   <= '0;
      st_phase <= ~st_phase;
    end
    else
      st_cnt <= st_cnt + 1'b1;
  end

  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    wire [3:0] mask = ctrl[c].src_mask & sens_en;
    wire inv = thr_on[c] < thr_off[c];
    wire [2:0] n = pop4(mask);
    logic [3:0]  votes;
    logic        avg_cond;
    logic [17:0] sum;
    logic [11:0] timer;
    wire [18:0] on_s = {3'h0, thr_on[c]} * {16'h0000, n};
    wire [18:0] off_s = {3'h0, thr_off[c]} * {16'h0000, n};
    wire [18:0] sum_w = {1'b0, sum};

    always_comb
    begin
      sum = 18'h0;
      for (int i = 0; i < NSENS; i++)
        if (mask[i])
          sum = sum + {2'h0, I_READING[i]};
    end

    for (genvar i = 0; i < NSENS; i++)
    begin : g_vote
      always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
      begin
        if (!I_ARST_N)
          votes[i] <= 1'b0;
        else if (!mask[i])
          votes[i] <= 1'b0;
        else if (inv)
        begin
          if (I_READING[i] < thr_on[c])
            votes[i] <= 1'b1;
          else if (I_READING[i] > thr_off[c])
            votes[i] <= 1'b0;
        end
        else if (I_READING[i] >= thr_on[c])
          votes[i] <= 1'b1;
        else if (I_READING[i] <= thr_off[c])
          votes[i] <= 1'b0;
      end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
      if (!I_ARST_N)
        avg_cond <= 1'b0;
      else if (n == 3'h0)
        avg_cond <= 1'b0;
      else if (inv)
      begin
        if (sum_w <= on_s)
          avg_cond <= 1'b1;
        else if (sum_w >= off_s)
          avg_cond <= 1'b0;
      end
      // mean compared as sum against threshold times count
      else if (sum_w >= on_s)
        avg_cond <= 1'b1;
      else if (sum_w <= off_s)
        avg_cond <= 1'b0;
    end

    // vote count reaches minimum; averaging ignores it
    wire cond = ctrl[c].en && (n != 3'h0) &&
                (ctrl[c].avg ? avg_cond : (pop4(votes & mask) >= ctrl[c].vote));
    wire hushable = (c >= 4) || ctrl[c].bstyle;
    wire [11:0] target = act[c] ?
      12'(dly_off[c]) * 12'(`AOV_SEC_PER_MIN) :
      12'(dly_on[c]) * 12'(`AOV_SEC_PER_MIN);
    wire pend = (cond != act[c]) && !(act[c] && ctrl[c].latch && (c < 4));

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
      if (!I_ARST_N)
      begin
        act[c]    <= 1'b0;
        hushed[c] <= 1'b0;
        timer     <= 12'h000;
      end
      else if (!ctrl[c].en)
      begin
        act[c]    <= 1'b0;
        hushed[c] <= 1'b0;
        timer     <= 12'h000;
      end
      else if (cmd_unhush && hushed[c])
      begin
        hushed[c] <= 1'b0;
        act[c]    <= 1'b0;
        timer     <= 12'h000;
      end
      else
      begin
        if (cmd_hush && hushable && act[c])
          hushed[c] <= 1'b1;
        else if (!act[c])
          hushed[c] <= 1'b0;
        if (cmd_rstlat && act[c] && !cond)
        begin
          act[c] <= 1'b0;
          timer  <= 12'h000;
        end
        else if (pend)
        begin
          if (timer >= target)
          begin
            act[c] <= cond;
            timer  <= 12'h000;
          end
          else if (sec_tick)
            timer <= timer + 12'h001;
        end
        else
          timer <= 12'h000;
      end
    end
  end

  // Front panel modes
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      front    <= FP_MON;
      row      <= 3'h0;
      hold_s   <= 8'h00;
      unlocked <= 1'b0;
    end
    else
    begin
      unique case (front)
        FP_MON:
        begin
          if (I_KEY_UP || I_KEY_DOWN)
          begin
            front  <= FP_HOLD;
            hold_s <= 8'h00;
            row    <= I_KEY_UP ? row - 3'h1 : row + 3'h1;
          end
          else if (I_KEY_ENTER)
            front <= FP_MENU;
        end
        FP_HOLD:
        begin
          if (I_KEY_EXIT)
            front <= FP_MON;
          else if (I_KEY_UP || I_KEY_DOWN)
          begin
            hold_s <= 8'h00;
            row    <= I_KEY_UP ? row - 3'h1 : row + 3'h1;
          end
          else if (sec_tick)
          begin
            if ({4'h0, hold_s} >= hold_last)
              front <= FP_MON;
            else
              hold_s <= hold_s + 8'h01;
          end
        end
        FP_MENU:
        begin
          if (I_KEY_EXIT)
          begin
            front    <= FP_MON;
            unlocked <= 1'b0;
          end
          else if (I_WR && (I_ADDR == `AOV_A_UNLOCK) &&
                   (I_WDATA[15:0] == password))
            unlocked <= 1'b1;
        end
        default: front <= FP_MON;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      bl_s  <= 4'h0;
      bl_on <= 1'b0;
    end
    else if (key_any)
    begin
      bl_s  <= 4'h0;
      bl_on <= 1'b1;
    end
    else if (sec_tick && bl_on)
    begin
      if (bl_s >= 4'(`AOV_BL_S - 1))
        bl_on <= 1'b0;
      else
        bl_s <= bl_s + 4'h1;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      beep_cnt <= '0;
    else if (key_any && beep_en)
      beep_cnt <= BPW'(BEEP_CYC);
    else if (beep_cnt != '0)
      beep_cnt <= beep_cnt - 1'b1;
  end

  // Outputs
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_RELAY_COIL  <= 4'h0;
      O_RELAY_LED   <= 4'h0;
      O_BUZZER      <= 3'h0;
      O_HORN        <= 1'b0;
      O_STROBE      <= 1'b0;
      O_SENS_TX_LED <= 1'b0;
      O_SENS_RX_LED <= 1'b0;
      O_MST_TX_LED  <= 1'b0;
      O_MST_RX_LED  <= 1'b0;
      O_BACKLIGHT   <= 1'b0;
      O_BEEP        <= 1'b0;
    end
    else
    begin
      // channels 0-3 relays, 4-6 buzzers, 7 strobe
      for (int r = 0; r < 4; r++)
      begin
        O_RELAY_COIL[r] <= ctrl[r].en &&
          ((act[r] && !hushed[r]) ^ ctrl[r].energ);
        O_RELAY_LED[r]  <= ctrl[r].en &&
          ((act[r] && !hushed[r]) ^ ctrl[r].energ);
      end
      O_BUZZER <= act[6:4] & ~hushed[6:4];
      O_HORN   <= |(act[6:4] & ~hushed[6:4]);
      O_STROBE <= act[7] && !hushed[7] && (!strobe_half || st_phase);
      O_SENS_TX_LED <= I_SENS_TX_ACT;
      O_SENS_RX_LED <= I_SENS_RX_ACT;
      O_MST_TX_LED  <= I_MST_TX_ACT;
      O_MST_RX_LED  <= I_MST_RX_ACT;
      O_BACKLIGHT <= (bl_mode == BL_ON) || ((bl_mode == BL_AUTO) && bl_on);
      O_BEEP      <= (beep_cnt != '0);
    end
  end

  assign O_AUTO_SCROLL = (front == FP_MON);
  assign O_HOLD = (front == FP_HOLD);
  assign O_MENU = (front == FP_MENU);
  assign O_HOLD_ROW = row;
  assign O_MB_CFG = mb_cfg;

  // Read data, one cycle after strobe
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      O_RDATA <= 32'h0;
    else if (!I_RD)
      O_RDATA <= 32'h0;
    else if (ch_hit)
    begin
      unique case (ch_word)
        `AOV_W_CTRL: O_RDATA <= {19'h0, act[ch_sel], ctrl[ch_sel]};
        `AOV_W_THR_ON: O_RDATA <= {16'h0, thr_on[ch_sel]};
        `AOV_W_THR_OFF: O_RDATA <= {16'h0, thr_off[ch_sel]};
        `AOV_W_DELAY: O_RDATA <= {18'h0, dly_off[ch_sel], 2'h0, dly_on[ch_sel]};
      endcase
    end
    else
    begin
      unique case (I_ADDR)
        `AOV_A_SYS: O_RDATA <= {28'h0, strobe_half, beep_en, bl_mode};
        `AOV_A_PASS: O_RDATA <= {16'h0, password};
        `AOV_A_MBADDR: O_RDATA <= {24'h0, mb_cfg.addr};
        `AOV_A_MBBAUD: O_RDATA <= mb_cfg.baud;
        `AOV_A_MBPAR: O_RDATA <= {30'h0, mb_cfg.parity};
        `AOV_A_STATUS: O_RDATA <= {10'h0, hushed, row, unlocked, front, act};
        `AOV_A_SENS_EN: O_RDATA <= {28'h0, sens_en};
        default: O_RDATA <= 32'h0;
      endcase
    end
  end
endmodule : aov_top

// [testbench/aov_top_props.sv]
`timescale 1ns/100ps
module aov_top_chk
  import aov_pkg::*;
#(
  parameter int CYC_PER_SEC = 10,
  parameter int BEEP_CYC    = 3
)(
  input wire logic        I_CORE_CLK,
  input wire logic        I_ARST_N,
  input wire logic        I_RD,
  input wire logic        I_KEY_UP,
  input wire logic        I_KEY_DOWN,
  input wire logic        I_KEY_ENTER,
  input wire logic        I_KEY_EXIT,
  input wire logic        I_SENS_TX_ACT,
  input wire logic        I_SENS_RX_ACT,
  input wire logic        I_MST_TX_ACT,
  input wire logic        I_MST_RX_ACT,
  input wire logic [31:0] O_RDATA,
  input wire logic [3:0]  O_RELAY_COIL,
  input wire logic [3:0]  O_RELAY_LED,
  input wire logic [2:0]  O_BUZZER,
  input wire logic        O_HORN,
  input wire logic        O_SENS_TX_LED,
  input wire logic        O_SENS_RX_LED,
  input wire logic        O_MST_TX_LED,
  input wire logic        O_MST_RX_LED,
  input wire logic        O_AUTO_SCROLL,
  input wire logic        O_HOLD,
  input wire logic        O_MENU,
  input wire logic [2:0]  O_HOLD_ROW,
  input wire logic        O_BEEP
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);
  localparam int HOLD_MAX = 181 * CYC_PER_SEC + 2;
  logic [15:0] hold_cnt;
  logic [7:0]  beep_cnt;
  logic        key_any;
  assign key_any = I_KEY_UP | I_KEY_DOWN | I_KEY_ENTER | I_KEY_EXIT;
  // Cycles spent in hold since the last scroll key
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      hold_cnt <= 16'h0000;
    else if (!O_HOLD || I_KEY_UP || I_KEY_DOWN)
      hold_cnt <= 16'h0000;
    else
      hold_cnt <= hold_cnt + 16'h0001;
  end
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      beep_cnt <= 8'h00;
    else if (key_any || !O_BEEP)
      beep_cnt <= 8'h00;
    else
      beep_cnt <= beep_cnt + 8'h01;
  end
  a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
    else $error("read data outside read slot");
  a_led_coil: assert property (O_RELAY_LED == O_RELAY_COIL)
    else $error("relay indicator differs from coil");
  a_horn_any: assert property ((|O_BUZZER) |-> ##[0:1] O_HORN)
    else $error("horn silent with buzzer on");
  a_comm_leds: assert property ($past(I_ARST_N, 2) |->
    {O_SENS_TX_LED, O_SENS_RX_LED, O_MST_TX_LED, O_MST_RX_LED} ==
    $past({I_SENS_TX_ACT, I_SENS_RX_ACT, I_MST_TX_ACT, I_MST_RX_ACT}))
    else $error("activity indicator wrong");
  a_hold_entry: assert property ((O_AUTO_SCROLL &&
    (I_KEY_UP || I_KEY_DOWN) && !I_KEY_ENTER) |=> O_HOLD)
    else $error("scroll key did not enter hold");
  a_row_step: assert property ((O_AUTO_SCROLL && I_KEY_UP &&
    !I_KEY_DOWN) |=> O_HOLD_ROW == $past(O_HOLD_ROW) - 3'h1)
    else $error("hold row not stepped");
  a_hold_exit: assert property ((O_HOLD && I_KEY_EXIT &&
    !I_KEY_UP && !I_KEY_DOWN) |=> O_AUTO_SCROLL)
    else $error("exit key did not leave hold");
  a_menu_gate: assert property ($rose(O_MENU) |->
    $past(O_AUTO_SCROLL) && $past(I_KEY_ENTER))
    else $error("menu entered outside monitoring");
  a_hold_bound: assert property (hold_cnt <= HOLD_MAX)
    else $error("hold outlived its timeout");
  a_beep_len: assert property (beep_cnt <= BEEP_CYC + 1)
    else $error("key beep too long");
  c_hold: cover property ($rose(O_HOLD));
  c_menu: cover property ($rose(O_MENU));
  c_horn: cover property ($rose(O_HORN));
endmodule : aov_top_chk

bind aov_top aov_top_chk #(.CYC_PER_SEC(CYC_PER_SEC), .BEEP_CYC(BEEP_CYC))
  i_chk (.*);

// [testbench/aov_sensor_model.sv]
`timescale 1ns/100ps
module aov_sensor_model
  import aov_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [3:0][15:0] i_level,
  output logic      [3:0][15:0] o_reading,
  output logic                  o_tx_act,
  output logic                  o_rx_act
);
  logic [2:0] phase;
  // Poll every eight cycles: request, reply, then new readings
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      phase <= 3'h0;
    else
      phase <= phase + 3'h1;
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_reading <= '0;
    else if (phase == 3'h3)
      o_reading <= i_level;
  end
  assign o_tx_act = (phase < 3'h2);
  assign o_rx_act = (phase == 3'h2) || (phase == 3'h3);
endmodule : aov_sensor_model

// [testbench/aov_top_tb.sv]
`timescale 1ns/100ps
module aov_top_tb
  import aov_pkg::*;
();
  localparam int CPS = 10;
  logic             clk;
  logic             rst_n;
  logic [7:0]       addr;
  logic [31:0]      wdata;
  logic             wr;
  logic             rd;
  logic [31:0]      rdata;
  logic [3:0][15:0] lvl;
  logic [3:0][15:0] rdg;
  logic [3:0]       keys;
  logic             stx;
  logic             srx;
  logic [1:0]       mact;
  logic [3:0]       coil;
  logic [3:0]       led;
  logic [2:0]       buz;
  logic             horn;
  logic             strb;
  logic [3:0]       ind;
  logic             auto;
  logic             hold;
  logic             menu;
  logic [2:0]       row;
  logic             beep;
  logic             bl;
  aov_mb_cfg_t      mb;
  int               errors;
  int               checks;
  int               cnt;
  int               tmo;
  logic [7:0]       ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                               8'h20, 8'h3C};
  logic [31:0]      rv [8] = '{32'h6, 32'h4321, 32'h3, 32'h4B00, 32'h0,
                               32'h0, 32'h0, 32'h0};
  aov_sensor_model i_sens (.i_clk(clk), .i_rst_n(rst_n), .i_level(lvl),
    .o_reading(rdg), .o_tx_act(stx), .o_rx_act(srx));
  aov_top #(.CYC_PER_SEC(CPS), .BEEP_CYC(3), .STROBE_HALF_CYC(4)) i_dut (
    .I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_READING(rdg),
    .I_KEY_UP(keys[3]), .I_KEY_DOWN(keys[2]), .I_KEY_ENTER(keys[1]),
    .I_KEY_EXIT(keys[0]), .I_SENS_TX_ACT(stx), .I_SENS_RX_ACT(srx),
    .I_MST_TX_ACT(mact[1]), .I_MST_RX_ACT(mact[0]), .O_RELAY_COIL(coil),
    .O_RELAY_LED(led), .O_BUZZER(buz), .O_HORN(horn), .O_STROBE(strb),
    .O_SENS_TX_LED(ind[3]), .O_SENS_RX_LED(ind[2]), .O_MST_TX_LED(ind[1]),
    .O_MST_RX_LED(ind[0]), .O_AUTO_SCROLL(auto), .O_HOLD(hold),
    .O_MENU(menu), .O_HOLD_ROW(row), .O_BEEP(beep), .O_BACKLIGHT(bl),
    .O_MB_CFG(mb));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_reg
  task automatic cfg(input logic [2:0] c, input logic [31:0] ctl,
                     input logic [15:0] on, input logic [15:0] off);
    wr_reg(8'h44 + {1'b0, c, 4'h0}, {16'h0, on});
    wr_reg(8'h48 + {1'b0, c, 4'h0}, {16'h0, off});
    wr_reg(8'h40 + {1'b0, c, 4'h0}, ctl);
  endtask : cfg
  task automatic setl(input logic [3:0][15:0] v);
    @(posedge clk);
    lvl <= v;
    cyc(16);
  endtask : setl
  task automatic key(input logic [3:0] k);
    @(posedge clk);
    keys <= k;
    @(posedge clk);
    keys <= 4'h0;
    #1;
  endtask : key
  task automatic strobe_hi(input int e);
    cnt = 0;
    repeat (16)
    begin
      @(posedge clk);
      #1;
      cnt += int'(strb === 1'b1);
    end
    chk(cnt, e);
  endtask : strobe_hi
  always @(posedge clk)
  begin
    tmo++;
    if (tmo == 12000)
    begin
      errors++;
      end_sim();
    end
  end
  initial
  begin
    errors = 0;
    checks = 0;
    tmo = 0;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    keys = 4'h0;
    mact = 2'h0;
    lvl = {4{16'h0028}};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(mb, {8'h03, 32'h0000_4B00, 2'h0});
    for (int i = 0; i < 8; i++)
      rd_reg(ra[i], rv[i]);
    wr_reg(8'h04, 32'h0000_12A4);
    rd_reg(8'h04, 32'h0000_4321);
    wr_reg(8'h04, 32'h0000_0987);
    rd_reg(8'h04, 32'h0000_0987);
    wr_reg(8'h20, 32'h0000_000F);
    cfg(3'h0, 32'h982, 16'h0064, 16'h0032);
    cfg(3'h1, 32'hA01, 16'h0014, 16'h003C);
    cfg(3'h2, 32'h9C4, 16'h0064, 16'h003C);
    cfg(3'h3, 32'hC11, 16'h0064, 16'h0032);
    cfg(3'h4, 32'h881, 16'h0064, 16'h0032);
    cfg(3'h7, 32'h881, 16'h0064, 16'h0032);
    cyc(16);
    chk({led, coil}, 8'h88);
    setl({16'h0028, 16'h0028, 16'h0028, 16'h0078});
    chk(coil, 4'h8);
    chk({horn, buz}, 4'h9);
    strobe_hi(16);
    wr_reg(8'h00, 32'hE);
    strobe_hi(8);
    wr_reg(8'h00, 32'h6);
    wr_reg(8'h14, 32'h4);
    cyc(4);
    chk(buz, 3'h0);
    wr_reg(8'h14, 32'h2);
    cyc(4);
    chk(buz, 3'h1);
    setl({16'h0028, 16'h0028, 16'h0078, 16'h0078});
    chk(coil, 4'hD);
    setl({16'h0028, 16'h0028, 16'h0078, 16'h0046});
    chk(coil, 4'hD);
    setl({16'h0028, 16'h0028, 16'h0078, 16'h0032});
    chk(coil, 4'hC);
    setl({16'h00C8, 16'h000A, 16'h0028, 16'h0032});
    chk({led, coil}, 8'h22);
    setl({16'h00C8, 16'h0028, 16'h0028, 16'h0032});
    chk(coil, 4'h2);
    setl({16'h0028, 16'h0046, 16'h0028, 16'h0032});
    chk(coil, 4'h8);
    cfg(3'h0, 32'h9A2, 16'h0064, 16'h0032);
    setl({16'h0028, 16'h0046, 16'h0078, 16'h0078});
    wr_reg(8'h14, 32'h1);
    cyc(4);
    chk(coil[0], 1'b1);
    setl({16'h0028, 16'h0046, 16'h0028, 16'h0028});
    chk(coil[0], 1'b1);
    wr_reg(8'h14, 32'h1);
    cyc(4);
    chk(coil[0], 1'b0);
    cfg(3'h2, 32'h9C4, 16'h001E, 16'h0050);
    setl({16'h0028, 16'h0046, 16'h0014, 16'h0014});
    chk(coil, 4'hC);
    setl({16'h0028, 16'h0046, 16'h0050, 16'h0050});
    chk(coil, 4'h8);
    mact <= 2'h3;
    cyc(3);
    chk(ind[1:0], 2'h3);
    key(4'h8);
    chk({auto, hold, row}, 5'h0F);
    key(4'h2);
    chk(menu, 1'b0);
    key(4'h1);
    chk(auto, 1'b1);
    key(4'h2);
    chk(menu, 1'b1);
    key(4'h1);
    chk(auto, 1'b1);
    key(4'h4);
    cyc(1);
    chk({bl, beep}, 2'h3);
    cyc(10 * CPS - CPS - 3);
    chk(bl, 1'b1);
    cyc(2 * CPS + 4);
    chk(bl, 1'b0);
    cyc(167 * CPS + 3);
    chk(hold, 1'b1);
    cyc(2 * CPS + 6);
    chk(auto, 1'b1);
    wr_reg(8'h00, 32'h4);
    cyc(2);
    chk(bl, 1'b1);
    wr_reg(8'h00, 32'h5);
    cyc(2);
    chk(bl, 1'b0);
    end_sim();
  end
endmodule : aov_top_tb
